//--- hdl/nvc_regs.svh
// Register map and field positions of the nonvolatile controller register block
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

`define NVC_OFS_COMMAND      8'h00
`define NVC_OFS_PROTECT      8'h01
`define NVC_OFS_STATUS       8'h02
`define NVC_OFS_INT_ENABLE   8'h03
`define NVC_OFS_INT_FLAG     8'h04
`define NVC_OFS_DATA_LOW     8'h06
`define NVC_OFS_DATA_HIGH    8'h07
`define NVC_OFS_ADDR_LOW     8'h08
`define NVC_OFS_ADDR_HIGH    8'h09

`define NVC_BIT_APP_WP       0
`define NVC_BIT_BOOT_LOCK    1
`define NVC_BIT_FLASH_ACT    0
`define NVC_BIT_EEPROM_ACT   1
`define NVC_BIT_WRITE_FAULT  2
`define NVC_BIT_EE_IDLE      0

`define NVC_ZERO8            8'h00
`define NVC_ZERO16           16'h0000
`define NVC_ZERO3            3'h0

`endif

//--- hdl/nvc_pkg.sv
// Types shared by the nonvolatile controller register block
package nvc_pkg;

  typedef enum logic [2:0] {
    NVC_CMD_NONE,
    NVC_CMD_WRITE_PAGE,
    NVC_CMD_ERASE_PAGE,
    NVC_CMD_ERASE_WRITE,
    NVC_CMD_BUF_CLEAR,
    NVC_CMD_CHIP_ERASE,
    NVC_CMD_EEPROM_ERASE,
    NVC_CMD_FUSE_WRITE
  } nvc_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       from_debug;
  } nvc_bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        fault;
  } nvc_done_t;

  typedef struct packed {
    logic       valid;
    nvc_cmd_t   cmd;
  } nvc_cmd_req_t;

endpackage

//--- hdl/nvc_ctrl.sv
// Register block of the nonvolatile memory controller: protection, status, irq, data, address
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "nvc_regs.svh"

module nvc_ctrl (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset,
  input  wire nvc_pkg::nvc_bus_req_t i_bus,
  output logic [7:0]                 o_rdata,
  input  wire logic                  i_exec_in_boot,
  input  wire logic                  i_flash_active,
  input  wire logic                  i_eeprom_active,
  input  wire nvc_pkg::nvc_done_t    i_done,
  input  wire logic [15:0]           i_boot_rdata,
  output logic [15:0]                o_boot_rdata,
  output nvc_pkg::nvc_cmd_req_t      o_cmd,
  output logic [15:0]                o_write_data,
  output logic [15:0]                o_target_address,
  output logic                       o_app_write_protect,
  output logic                       o_boot_read_lock,
  output logic                       o_irq
);
  import nvc_pkg::*;

  // ==========================================================
  // State
  logic        app_wp_q;
  logic        boot_armed_q;
  logic        boot_lock_q;
  logic        was_in_boot_q;
  logic        write_fault_q;
  logic        irq_en_q;
  logic        ee_idle_q;
  logic [15:0] data_q;
  logic [15:0] addr_q;
  logic [7:0]  rdata_q;
  logic [7:0]  status_d;
  nvc_cmd_req_t cmd_q;
  logic        wr_ctl;
  logic        wr_pro;
  logic        clr_idle;
  nvc_cmd_t    cmd_w;

  assign wr_ctl   = i_bus.wr && (i_bus.addr == `NVC_OFS_COMMAND);
  assign wr_pro   = i_bus.wr && (i_bus.addr == `NVC_OFS_PROTECT);
  assign clr_idle = i_bus.wr && (i_bus.addr == `NVC_OFS_INT_FLAG)
                    && i_bus.wdata[`NVC_BIT_EE_IDLE];
  assign cmd_w    = nvc_cmd_t'(i_bus.wdata[2:0]);

  // ==========================================================
  // Section protection
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      app_wp_q <= 1'b0;
    end else if (wr_pro && i_bus.wdata[`NVC_BIT_APP_WP]) begin
      app_wp_q <= 1'b1;
    end
  end

  // Arm on write from boot code; enforce after first exit
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      boot_armed_q <= 1'b0;
      boot_lock_q  <= 1'b0;
    end else begin
      if (wr_pro && i_bus.wdata[`NVC_BIT_BOOT_LOCK] && i_exec_in_boot) begin
        boot_armed_q <= 1'b1;
      end
      if ((boot_armed_q || boot_lock_q) && !i_exec_in_boot) begin
        boot_lock_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      was_in_boot_q <= 1'b0;
    end else begin
      was_in_boot_q <= i_exec_in_boot;
    end
  end

  assign o_boot_read_lock    = boot_lock_q;
  assign o_app_write_protect = app_wp_q;
  // Gating is combinational so the very first locked fetch is already zero
  assign o_boot_rdata = boot_lock_q ? `NVC_ZERO16 : i_boot_rdata;

  // ==========================================================
  // Commands
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cmd_q <= '0;
    end else begin
      cmd_q.valid <= 1'b0;
      cmd_q.cmd   <= NVC_CMD_NONE;
      if (wr_ctl && cmd_w != NVC_CMD_NONE
          && (cmd_w != NVC_CMD_FUSE_WRITE || i_bus.from_debug)) begin
        cmd_q.valid <= 1'b1;
        cmd_q.cmd   <= cmd_w;
      end
    end
  end
  assign o_cmd = cmd_q;

  // ==========================================================
  // Status
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      write_fault_q <= 1'b0;
    end else if (i_done.valid) begin
      write_fault_q <= i_done.fault;
    end
  end

  always_comb begin
    status_d = `NVC_ZERO8;
    status_d[`NVC_BIT_FLASH_ACT]   = i_flash_active;
    status_d[`NVC_BIT_EEPROM_ACT]  = i_eeprom_active;
    status_d[`NVC_BIT_WRITE_FAULT] = write_fault_q;
  end

  // ==========================================================
  // Interrupt
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_en_q <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == `NVC_OFS_INT_ENABLE) begin
      irq_en_q <= i_bus.wdata[`NVC_BIT_EE_IDLE];
    end
  end

  // Set wins over clear: idle level keeps the flag up
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ee_idle_q <= 1'b0;
    end else if (!i_eeprom_active && !i_reset) begin
      ee_idle_q <= 1'b1;
    end else if (clr_idle) begin
      ee_idle_q <= 1'b0;
    end
  end

  assign o_irq = irq_en_q && ee_idle_q;

  // ==========================================================
  // Data and address
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      data_q <= `NVC_ZERO16;
    end else if (i_bus.wr && i_bus.addr == `NVC_OFS_DATA_LOW) begin
      data_q[7:0] <= i_bus.wdata;
    end else if (i_bus.wr && i_bus.addr == `NVC_OFS_DATA_HIGH) begin
      data_q[15:8] <= i_bus.wdata;
    end
  end

  // Engine update wins over a software write in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      addr_q <= `NVC_ZERO16;
    end else if (i_done.valid) begin
      addr_q <= i_done.addr;
    end else if (i_bus.wr && i_bus.addr == `NVC_OFS_ADDR_LOW) begin
      addr_q[7:0] <= i_bus.wdata;
    end else if (i_bus.wr && i_bus.addr == `NVC_OFS_ADDR_HIGH) begin
      addr_q[15:8] <= i_bus.wdata;
    end
  end

  assign o_write_data     = data_q;
  assign o_target_address = addr_q;

  // ==========================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_q <= `NVC_ZERO8;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        `NVC_OFS_COMMAND:    rdata_q <= {5'h0_0, cmd_q.cmd};
        `NVC_OFS_PROTECT:    rdata_q <= {6'h00, boot_lock_q | boot_armed_q, app_wp_q};
        `NVC_OFS_STATUS:     rdata_q <= status_d;
        `NVC_OFS_INT_ENABLE: rdata_q <= {7'h00, irq_en_q};
        `NVC_OFS_INT_FLAG:   rdata_q <= {7'h00, ee_idle_q};
        `NVC_OFS_DATA_LOW:   rdata_q <= data_q[7:0];
        `NVC_OFS_DATA_HIGH:  rdata_q <= data_q[15:8];
        `NVC_OFS_ADDR_LOW:   rdata_q <= addr_q[7:0];
        `NVC_OFS_ADDR_HIGH:  rdata_q <= addr_q[15:8];
        default:             rdata_q <= `NVC_ZERO8;
      endcase
    end else begin
      rdata_q <= `NVC_ZERO8;
    end
  end
  assign o_rdata = rdata_q;

  // ==========================================================
  // Checks
  AST_BOOT_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    boot_lock_q |-> o_boot_rdata == `NVC_ZERO16)
    else $error("boot data not zero under lock");
  AST_BOOT_SOURCE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(boot_armed_q) |-> $past(i_exec_in_boot))
    else $error("boot lock armed from outside boot");
  AST_BOOT_DEFER: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (boot_armed_q && !boot_lock_q && i_exec_in_boot) |=> !boot_lock_q)
    else $error("boot lock enforced before leaving boot");
  AST_BOOT_ENTER: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (boot_armed_q && !i_exec_in_boot) |=> boot_lock_q)
    else $error("boot lock not enforced after exit");
  AST_APP_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    app_wp_q |=> app_wp_q)
    else $error("app protect dropped");
  AST_FAULT_LAST: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_done.valid |=> write_fault_q == $past(i_done.fault))
    else $error("write fault not from last op");
  AST_BUSY_BITS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_bus.rd && i_bus.addr == `NVC_OFS_STATUS
    |=> o_rdata[1:0] == $past({i_eeprom_active, i_flash_active}))
    else $error("busy bits wrong");
  AST_IRQ_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_irq == (irq_en_q && ee_idle_q))
    else $error("irq level wrong");
  AST_IDLE_SET: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !i_eeprom_active |=> ee_idle_q)
    else $error("idle flag not set");
  AST_IDLE_CLR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (clr_idle && i_eeprom_active) |=> !ee_idle_q)
    else $error("idle flag not cleared");
  AST_FUSE_GATE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr_ctl && cmd_w == NVC_CMD_FUSE_WRITE && !i_bus.from_debug) |=> !o_cmd.valid)
    else $error("fuse write taken from cpu");
  AST_ADDR_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.wr && i_bus.addr == `NVC_OFS_ADDR_HIGH && !i_done.valid)
    |=> addr_q[15:8] == $past(i_bus.wdata))
    else $error("address high byte not written");
  AST_ADDR_DONE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_done.valid |=> addr_q == $past(i_done.addr))
    else $error("address not updated");
  AST_DATA_LOW: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.wr && i_bus.addr == `NVC_OFS_DATA_LOW) |=> data_q[7:0] == $past(i_bus.wdata))
    else $error("data low byte not written");
  AST_RSVD_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_INT_FLAG) |=> o_rdata[7:1] == 7'h00)
    else $error("reserved bits not zero");

  // ==========================================================
  // Checks on read port and command decode
  AST_RDATA_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !i_bus.rd |=> o_rdata == `NVC_ZERO8)
    else $error("read data not zero outside read");

  AST_CMD_NONE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr_ctl && cmd_w == NVC_CMD_NONE) |=> !o_cmd.valid)
    else $error("no-command write gave a pulse");

  AST_CMD_TAKE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr_ctl && cmd_w != NVC_CMD_NONE && cmd_w != NVC_CMD_FUSE_WRITE)
    |=> (o_cmd.valid && o_cmd.cmd == $past(cmd_w)))
    else $error("command not issued");

  AST_FUSE_DEBUG: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr_ctl && cmd_w == NVC_CMD_FUSE_WRITE && i_bus.from_debug)
    |=> (o_cmd.valid && o_cmd.cmd == NVC_CMD_FUSE_WRITE))
    else $error("fuse write from debug port dropped");

  AST_CMD_CAUSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_cmd.valid |-> $past(wr_ctl))
    else $error("command pulse without write");

  // ==========================================================
  // Checks on protection
  AST_BOOT_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    boot_lock_q |=> boot_lock_q)
    else $error("boot lock dropped");

  AST_ARM_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    boot_armed_q |=> boot_armed_q)
    else $error("boot lock arming dropped");

  AST_BOOT_PASS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !boot_lock_q |-> o_boot_rdata == i_boot_rdata)
    else $error("boot data gated without lock");

  AST_LOCK_CAUSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(boot_lock_q) |-> ($past(boot_armed_q) && !$past(i_exec_in_boot)))
    else $error("boot lock enforced without arming and exit");

  // Registered copy shows execution had already left boot code
  AST_LOCK_EXIT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(boot_lock_q) |-> !was_in_boot_q)
    else $error("boot lock enforced inside boot");

  AST_ARM_IGNORE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr_pro && i_bus.wdata[`NVC_BIT_BOOT_LOCK] && !i_exec_in_boot && !boot_armed_q)
    |=> !boot_armed_q)
    else $error("boot lock armed from application code");

  AST_APP_SET: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr_pro && i_bus.wdata[`NVC_BIT_APP_WP]) |=> app_wp_q)
    else $error("app protect not set");

  AST_APP_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!app_wp_q && !(wr_pro && i_bus.wdata[`NVC_BIT_APP_WP])) |=> !app_wp_q)
    else $error("app protect set without write");

  // ==========================================================
  // Checks on status and interrupt
  AST_FAULT_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !i_done.valid |=> $stable(write_fault_q))
    else $error("write fault changed without operation end");

  AST_STATUS_FAULT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_STATUS)
    |=> o_rdata[`NVC_BIT_WRITE_FAULT] == $past(write_fault_q))
    else $error("write fault not readable");

  AST_STATUS_BUSY: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_STATUS)
    |=> o_rdata[`NVC_BIT_FLASH_ACT] == $past(i_flash_active))
    else $error("flash busy not readable");

  AST_STATUS_RSVD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_STATUS) |=> o_rdata[7:3] == 5'h00)
    else $error("status reserved bits not zero");

  AST_INTEN_RSVD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_INT_ENABLE) |=> o_rdata[7:1] == 7'h00)
    else $error("enable reserved bits not zero");

  AST_IRQ_EN_WR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.wr && i_bus.addr == `NVC_OFS_INT_ENABLE)
    |=> irq_en_q == $past(i_bus.wdata[`NVC_BIT_EE_IDLE]))
    else $error("interrupt enable not written");

  AST_IRQ_DROP: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !ee_idle_q |-> !o_irq)
    else $error("irq high with flag clear");

  AST_IDLE_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_eeprom_active && !clr_idle) |=> $stable(ee_idle_q))
    else $error("idle flag changed while busy");

  AST_FLAG_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_INT_FLAG) |=> o_rdata[0] == $past(ee_idle_q))
    else $error("idle flag not readable");

  // ==========================================================
  // Checks on data and address
  AST_DATA_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.wr && i_bus.addr == `NVC_OFS_DATA_HIGH) |=> data_q[15:8] == $past(i_bus.wdata))
    else $error("data high byte not written");

  AST_ADDR_LOW: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.wr && i_bus.addr == `NVC_OFS_ADDR_LOW && !i_done.valid)
    |=> addr_q[7:0] == $past(i_bus.wdata))
    else $error("address low byte not written");

  AST_DATA_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_DATA_LOW) |=> o_rdata == $past(data_q[7:0]))
    else $error("data low byte not readable");

  AST_ADDR_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_bus.rd && i_bus.addr == `NVC_OFS_ADDR_HIGH) |=> o_rdata == $past(addr_q[15:8]))
    else $error("address high byte not readable");

  AST_ADDR_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!i_done.valid && !(i_bus.wr && (i_bus.addr == `NVC_OFS_ADDR_LOW
                                     || i_bus.addr == `NVC_OFS_ADDR_HIGH)))
    |=> $stable(addr_q))
    else $error("address changed without update");

endmodule

//--- testbench/nvc_engine_model.sv
// Behavioural flash and EEPROM command engine facing the register block
`timescale 1ns/100ps
module nvc_engine_model #(parameter int LAT = 8) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset,
  input  wire nvc_pkg::nvc_cmd_req_t i_cmd,
  input  wire logic [15:0]           i_target_address,
  input  wire logic                  i_app_write_protect,
  output logic                       o_flash_active,
  output logic                       o_eeprom_active,
  output nvc_pkg::nvc_done_t         o_done
);
  import nvc_pkg::*;
  // ======
  // Engine
  int          cnt_q;
  logic        ee_q;
  logic        fault_q;
  logic [15:0] addr_q;
  assign o_flash_active  = (cnt_q != 0) && !ee_q;
  assign o_eeprom_active = (cnt_q != 0) && ee_q;
  // Protected writes fail, buffer clear never touches the array
  always_ff @(posedge i_sys_clk) begin
    o_done <= '0;
    if (i_reset) begin
      cnt_q <= 0;
      ee_q  <= 1'b0;
    end else if (i_cmd.valid) begin
      cnt_q   <= LAT;
      ee_q    <= (i_cmd.cmd == NVC_CMD_EEPROM_ERASE);
      fault_q <= i_app_write_protect && (i_cmd.cmd != NVC_CMD_BUF_CLEAR);
      addr_q  <= i_target_address + 16'h0002;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) begin
        o_done <= '{valid: 1'b1, addr: addr_q, fault: fault_q};
      end
    end
  end
endmodule

//--- testbench/nvc_ctrl_protect_status_regs_bench.sv
// Self-checking bench of the nonvolatile controller register block
`timescale 1ns/100ps
module nvc_ctrl_protect_status_regs_bench;
  import nvc_pkg::*;
  logic          i_sys_clk;
  logic          i_reset;
  nvc_bus_req_t  i_bus;
  logic [7:0]    o_rdata;
  logic          i_exec_in_boot;
  logic          flash_act;
  logic          ee_act;
  nvc_done_t     done;
  logic [15:0]   o_boot_rdata;
  nvc_cmd_req_t  o_cmd;
  logic [15:0]   o_write_data;
  logic [15:0]   o_target_address;
  logic          o_app_write_protect;
  logic          o_boot_read_lock;
  logic          o_irq;
  int            n_errors;
  int            check_count;
  int            cycles;
  // ======
  // Harness
  nvc_ctrl DUT (.i_sys_clk, .i_reset, .i_bus, .o_rdata, .i_exec_in_boot,
    .i_flash_active(flash_act), .i_eeprom_active(ee_act), .i_done(done),
    .i_boot_rdata(16'hA5C3), .o_boot_rdata, .o_cmd, .o_write_data, .o_target_address,
    .o_app_write_protect, .o_boot_read_lock, .o_irq);
  nvc_engine_model ENG (.i_sys_clk, .i_reset, .i_cmd(o_cmd), .i_target_address(o_target_address),
    .i_app_write_protect(o_app_write_protect), .o_flash_active(flash_act),
    .o_eeprom_active(ee_act), .o_done(done));
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  // ======
  // Tasks
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dbg = 1'b0);
    @(posedge i_sys_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, from_debug: dbg};
    @(posedge i_sys_clk);
    i_bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_bus.addr <= a;
    i_bus.rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_bus.rd <= 1'b0;
    #1;
    chk({8'h00, o_rdata}, {8'h00, exp});
  endtask
  task automatic wait_idle();
    // Busy rises two edges after the command write; do not test it before
    repeat (2) @(posedge i_sys_clk);
    #1;
    for (int i = 0; i < 30 && (flash_act || ee_act); i++) begin
      @(posedge i_sys_clk);
      #1;
    end
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
  endtask
  // ======
  // Scenarios
  task automatic t_map();
    for (int a = 0; a < 10; a++) rchk(a[7:0], (a == 4) ? 8'h01 : 8'h00);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h01);
    rchk(8'h04, 8'h01);
    chk(o_irq, 1'b1);
    wr(8'h03, 8'h00);
    chk(o_irq, 1'b0);
  endtask
  task automatic t_data();
    wr(8'h06, 8'h34);
    wr(8'h07, 8'h12, 1'b1);
    wr(8'h08, 8'h78);
    wr(8'h09, 8'h56);
    chk(o_write_data, 16'h1234);
    chk(o_target_address, 16'h5678);
    rchk(8'h07, 8'h12);
    rchk(8'h08, 8'h78);
  endtask
  task automatic t_cmd();
    logic [15:0] ea;
    ea = 16'h5678;
    for (int c = 0; c < 8; c++) begin
      for (int g = 0; g < 2; g++) begin
        wr(8'h00, {5'h00, c[2:0]}, g[0]);
        if (c == 0 || (c == 7 && g == 0)) begin
          chk({12'h000, o_cmd}, 16'h0000);
        end else begin
          chk({12'h000, o_cmd}, {12'h000, 1'b1, c[2:0]});
          rchk(8'h02, (c == 6) ? 8'h02 : 8'h01);
          wait_idle();
          ea = ea + 16'h0002;
          chk(o_target_address, ea);
          rchk(8'h02, 8'h00);
        end
      end
    end
  endtask
  task automatic t_irq();
    wr(8'h00, 8'h06);
    wr(8'h04, 8'h01);
    rchk(8'h04, 8'h00);
    wr(8'h03, 8'h01);
    chk(o_irq, 1'b0);
    wait_idle();
    chk(o_irq, 1'b1);
    rchk(8'h04, 8'h01);
    wr(8'h03, 8'h00);
    chk(o_irq, 1'b0);
  endtask
  task automatic t_protect();
    wr(8'h01, 8'h02);
    rchk(8'h01, 8'h00);
    @(posedge i_sys_clk);
    i_exec_in_boot <= 1'b1;
    wr(8'h01, 8'h03);
    wr(8'h01, 8'h00);
    rchk(8'h01, 8'h03);
    chk(o_boot_read_lock, 1'b0);
    chk(o_boot_rdata, 16'hA5C3);
    chk(o_app_write_protect, 1'b1);
    @(posedge i_sys_clk);
    i_exec_in_boot <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk(o_boot_read_lock, 1'b1);
    chk(o_boot_rdata, 16'h0000);
    wr(8'h00, 8'h01);
    wait_idle();
    rchk(8'h02, 8'h04);
    wr(8'h00, 8'h04);
    wait_idle();
    rchk(8'h02, 8'h00);
    do_reset();
    rchk(8'h01, 8'h00);
  endtask
  // ======
  // Main sequence
  initial begin
    n_errors       = 0;
    check_count    = 0;
    cycles         = 0;
    i_bus          = '0;
    i_exec_in_boot = 1'b0;
    do_reset();
    t_map();
    t_data();
    t_cmd();
    t_irq();
    t_protect();
    end_sim();
  end
endmodule
